/* rtl/dpw_cfg.svh */
`ifndef DPW_CFG_SVH
`define DPW_CFG_SVH

// command codes
`define DPW_CMD_WIPER_A     8'h11
`define DPW_CMD_WIPER_B     8'h12
`define DPW_CMD_WIPER_BOTH  8'h13
// slave address upper four bits
`define DPW_ADDR_PREFIX     4'h5
// reset position of both wipers, midscale
`define DPW_WIPER_RESET     8'h80
// last bit index of a byte and bit counter reset
`define DPW_BIT_LAST        3'h7
`define DPW_BIT_RESET       3'h0

`endif

/* rtl/dpw_pkg.sv */
package dpw_pkg;

  typedef enum logic [2:0] {
    DPW_IDLE,
    DPW_ADDR,
    DPW_ACK,
    DPW_CMD,
    DPW_DATA,
    DPW_SKIP
  } dpw_state_type;

  // one byte phase tracker: which byte of the frame comes next
  typedef enum logic [1:0] {
    DPW_BYTE_ADDR,
    DPW_BYTE_CMD,
    DPW_BYTE_DATA,
    DPW_BYTE_DONE
  } dpw_byte_type;

  // sampled bus lines with their edges
  typedef struct packed {
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } dpw_line_type;

  // wiper write request
  typedef struct packed {
    logic       load_a;
    logic       load_b;
    logic [7:0] value;
  } dpw_load_type;

endpackage

/* rtl/dpw_line_sense.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dpw_cfg.svh"

module dpw_line_sense (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ce,
  // raw bus levels
  input  wire logic              scl_in,
  input  wire logic              sda_in,
  // decoded lines
  output dpw_pkg::dpw_line_type  line
);

  typedef struct packed {
    logic scl;
    logic sda;
  } dpw_ls_state_type;

  dpw_ls_state_type st_r;
  dpw_ls_state_type st_nxt;

  // remember previous levels
  always_comb begin
    st_nxt     = st_r;
    st_nxt.scl = scl_in;
    st_nxt.sda = sda_in;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '{scl: 1'b1, sda: 1'b1};
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // edges and start/stop conditions
  always_comb begin
    line.scl      = scl_in;
    line.sda      = sda_in;
    line.scl_rise = scl_in & ~st_r.scl;
    line.scl_fall = ~scl_in & st_r.scl;
    line.start    = scl_in & st_r.scl & st_r.sda & ~sda_in;
    line.stop     = scl_in & st_r.scl & ~st_r.sda & sda_in;
  end

endmodule
`default_nettype wire

/* rtl/dpw_wiper.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dpw_cfg.svh"

module dpw_wiper (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // load strobe
  input  wire logic        load,
  input  wire logic [7:0]  value,
  // tap index
  output logic [7:0]       tap
);

  typedef struct packed {
    logic [7:0] tap;
  } dpw_wp_state_type;

  dpw_wp_state_type st_r;
  dpw_wp_state_type st_nxt;

  // volatile position, tap follows a write at once
  always_comb begin
    st_nxt = st_r;
    if (load) begin
      st_nxt.tap = value;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r.tap <= `DPW_WIPER_RESET;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign tap = st_r.tap;

endmodule
`default_nettype wire

/* rtl/dpw_slave.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dpw_cfg.svh"

//////////////////////////////////////////////////////////////////////////////
// How it works
// - command 0x11 then data byte loads wiper A
// - command 0x12 then data byte loads wiper B
// - command 0x13 then data byte loads both wipers together
// - position is the single 8-bit data byte after the command
// - each wiper has 256 taps, one per data byte value
// - device never drives data; reads get no acknowledge
// - writes go to volatile storage, wiper follows at once
// - data value is the tap index; 0xFF is highest tap
// - both wipers start at midscale
// - one of eight addresses chosen by select pins
// - address is 0101 then the three select pin levels
module dpw_slave (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // two-wire bus
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n,
  // address select pins
  input  wire logic        addr_select_msb,
  input  wire logic        addr_select_mid,
  input  wire logic        addr_select_lsb,
  // wiper tap indices
  output logic [7:0]       wiper_out_first,
  output logic [7:0]       wiper_out_second
);

  dpw_pkg::dpw_line_type line;
  dpw_pkg::dpw_load_type load;
  logic [7:0]            tap_a;
  logic [7:0]            tap_b;
  logic [6:0]            own_addr;

  typedef struct packed {
    dpw_pkg::dpw_state_type state;
    dpw_pkg::dpw_byte_type  next_byte;
    logic [2:0]             bit_cnt;
    logic                   bit_open;
    logic [7:0]             shift;
    logic [7:0]             command;
    logic                   ack_drive;
    dpw_pkg::dpw_load_type  load;
    logic                   sda_oe_n;
    logic [7:0]             out_a;
    logic [7:0]             out_b;
  } dpw_state_struct_type;

  dpw_state_struct_type st_r;
  dpw_state_struct_type st_nxt;

  //////////////////////////////////////////////////////////////////////////////
  // line sensing
  dpw_line_sense u_sense (
    .clk    (clk),
    .rst    (rst),
    .ce     (ce),
    .scl_in (scl_in),
    .sda_in (sda_in),
    .line   (line)
  );

  // own address from prefix and select pins
  assign own_addr = {`DPW_ADDR_PREFIX, addr_select_msb, addr_select_mid, addr_select_lsb};

  //////////////////////////////////////////////////////////////////////////////
  // receive sequencer
  always_comb begin
    st_nxt      = st_r;
    st_nxt.load = '0;
    if (line.stop) begin
      st_nxt.state     = dpw_pkg::DPW_IDLE;
      st_nxt.ack_drive = 1'b0;
    end else if (line.start) begin
      st_nxt.state     = dpw_pkg::DPW_ADDR;
      st_nxt.next_byte = dpw_pkg::DPW_BYTE_ADDR;
      st_nxt.bit_cnt   = `DPW_BIT_RESET;
      st_nxt.bit_open  = 1'b0;
      st_nxt.ack_drive = 1'b0;
    end else begin
      case (st_r.state)
        dpw_pkg::DPW_IDLE: begin
          st_nxt.ack_drive = 1'b0;
        end
        dpw_pkg::DPW_ADDR, dpw_pkg::DPW_CMD, dpw_pkg::DPW_DATA: begin
          // shift in msb first on rising clock
          if (line.scl_rise) begin
            st_nxt.shift    = {st_r.shift[6:0], line.sda};
            st_nxt.bit_open = 1'b1;
          end
          // byte ends on the falling edge after the eighth bit;
          // a fall only closes a bit whose rise was seen, so the
          // fall that follows a start condition is not counted
          if (line.scl_fall && st_r.bit_open) begin
            st_nxt.bit_open = 1'b0;
            if (st_r.bit_cnt == `DPW_BIT_LAST) begin
              st_nxt.bit_cnt = `DPW_BIT_RESET;
              st_nxt.state   = dpw_pkg::DPW_ACK;
              case (st_r.state)
                dpw_pkg::DPW_ADDR: begin
                  // only writes to our address are acknowledged
                  if (st_r.shift[7:1] == own_addr && !st_r.shift[0]) begin
                    st_nxt.ack_drive = 1'b1;
                    st_nxt.next_byte = dpw_pkg::DPW_BYTE_CMD;
                  end else begin
                    st_nxt.state = dpw_pkg::DPW_IDLE;
                  end
                end
                dpw_pkg::DPW_CMD: begin
                  st_nxt.command   = st_r.shift;
                  st_nxt.ack_drive = 1'b1;
                  st_nxt.next_byte = dpw_pkg::DPW_BYTE_DATA;
                end
                default: begin
                  // data byte completes the write
                  st_nxt.ack_drive = 1'b1;
                  st_nxt.next_byte = dpw_pkg::DPW_BYTE_DONE;
                  case (st_r.command)
                    `DPW_CMD_WIPER_A: begin
                      st_nxt.load.load_a = 1'b1;
                    end
                    `DPW_CMD_WIPER_B: begin
                      st_nxt.load.load_b = 1'b1;
                    end
                    `DPW_CMD_WIPER_BOTH: begin
                      st_nxt.load.load_a = 1'b1;
                      st_nxt.load.load_b = 1'b1;
                    end
                    default: begin
                      st_nxt.load = '0;
                    end
                  endcase
                  st_nxt.load.value = st_r.shift;
                end
              endcase
            end else begin
              st_nxt.bit_cnt = st_r.bit_cnt + 3'h1;
            end
          end
        end
        dpw_pkg::DPW_ACK: begin
          // release after acknowledge clock pulse
          if (line.scl_fall) begin
            st_nxt.ack_drive = 1'b0;
            case (st_r.next_byte)
              dpw_pkg::DPW_BYTE_CMD: st_nxt.state = dpw_pkg::DPW_CMD;
              dpw_pkg::DPW_BYTE_DATA: st_nxt.state = dpw_pkg::DPW_DATA;
              default: st_nxt.state = dpw_pkg::DPW_SKIP;
            endcase
          end
        end
        dpw_pkg::DPW_SKIP: begin
          st_nxt.ack_drive = 1'b0;
        end
        default: begin
          st_nxt.state = dpw_pkg::DPW_IDLE;
        end
      endcase
    end
    // open-drain: drive low only while acknowledging
    st_nxt.sda_oe_n = ~st_nxt.ack_drive;
    st_nxt.out_a    = tap_a;
    st_nxt.out_b    = tap_b;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '{state: dpw_pkg::DPW_IDLE, next_byte: dpw_pkg::DPW_BYTE_ADDR,
                bit_cnt: `DPW_BIT_RESET, bit_open: 1'b0, shift: 8'h00, command: 8'h00,
                ack_drive: 1'b0, load: '0, sda_oe_n: 1'b1,
                out_a: `DPW_WIPER_RESET, out_b: `DPW_WIPER_RESET};
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign load = st_r.load;

  //////////////////////////////////////////////////////////////////////////////
  // wiper storage
  dpw_wiper u_wiper_a (
    .clk   (clk),
    .rst   (rst),
    .ce    (ce),
    .load  (load.load_a),
    .value (load.value),
    .tap   (tap_a)
  );

  dpw_wiper u_wiper_b (
    .clk   (clk),
    .rst   (rst),
    .ce    (ce),
    .load  (load.load_b),
    .value (load.value),
    .tap   (tap_b)
  );

  // outputs from flip-flops; 256 taps by full 8-bit index
  assign wiper_out_first  = st_r.out_a;
  assign wiper_out_second = st_r.out_b;
  assign sda_out          = 1'b0;
  assign sda_oe_n         = st_r.sda_oe_n;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  // wiper A output follows its load two cycles on
  load_a_out_a: assert property (@(posedge clk) disable iff (rst)
    (ce && load.load_a) ##1 ce [*1] ##1 1'b1 |-> wiper_out_first == $past(load.value, 2))
    else $error("wiper A did not follow write");

  // wiper B output follows its load two cycles on
  load_b_out_a: assert property (@(posedge clk) disable iff (rst)
    (ce && load.load_b) ##1 ce ##1 1'b1 |-> wiper_out_second == $past(load.value, 2))
    else $error("wiper B did not follow write");

  // a double load only comes from the both command
  both_same_a: assert property (@(posedge clk) disable iff (rst)
    (load.load_a && load.load_b) |-> st_r.command == `DPW_CMD_WIPER_BOTH)
    else $error("both load without both command");

  // no load without a known wiper command
  bad_cmd_a: assert property (@(posedge clk) disable iff (rst)
    (load.load_a || load.load_b) |-> (st_r.command inside {`DPW_CMD_WIPER_A, `DPW_CMD_WIPER_B,
                                                          `DPW_CMD_WIPER_BOTH}))
    else $error("wiper loaded by unknown command");

  // open-drain output only ever pulls low
  no_drive_high_a: assert property (@(posedge clk) disable iff (rst)
    !sda_oe_n |-> sda_out == 1'b0)
    else $error("data line driven high");

  // data line pulled only in the acknowledge slot
  ack_only_a: assert property (@(posedge clk) disable iff (rst)
    !sda_oe_n |-> st_r.state == dpw_pkg::DPW_ACK)
    else $error("data line driven outside acknowledge");

  // foreign address drops the frame
  addr_ack_a: assert property (@(posedge clk) disable iff (rst)
    (ce && st_r.state == dpw_pkg::DPW_ADDR && line.scl_fall && st_r.bit_open && st_r.bit_cnt == `DPW_BIT_LAST
     && !line.start && !line.stop && st_r.shift[7:1] != own_addr) |=> st_r.state == dpw_pkg::DPW_IDLE)
    else $error("foreign address acknowledged");

  // wipers at midscale on leaving reset
  mid_reset_a: assert property (@(posedge clk)
    $fell(rst) |-> wiper_out_first == `DPW_WIPER_RESET && wiper_out_second == `DPW_WIPER_RESET)
    else $error("wipers not at midscale after reset");

  // wiper A output moves only after a load of wiper A
  wiper_a_hold_a: assert property (@(posedge clk) disable iff (rst)
    ($changed(wiper_out_first) && $past(ce) && $past(ce, 2)) |-> $past(load.load_a, 2))
    else $error("wiper A moved without a write");

  // wiper B output moves only after a load of wiper B
  wiper_b_hold_a: assert property (@(posedge clk) disable iff (rst)
    ($changed(wiper_out_second) && $past(ce) && $past(ce, 2)) |-> $past(load.load_b, 2))
    else $error("wiper B moved without a write");

  // a both load leaves the two wipers equal
  both_equal_a: assert property (@(posedge clk) disable iff (rst)
    (ce && load.load_a && load.load_b) ##1 ce ##1 1'b1 |-> wiper_out_first == wiper_out_second)
    else $error("both write left wipers different");

  // tap index is the data byte itself, every value kept
  tap_index_a: assert property (@(posedge clk) disable iff (rst)
    (ce && load.load_b) |=> tap_b == $past(load.value))
    else $error("tap index differs from data byte");

  // unknown command at data byte end loads nothing
  unknown_cmd_a: assert property (@(posedge clk) disable iff (rst)
    (ce && st_r.state == dpw_pkg::DPW_DATA && line.scl_fall && st_r.bit_open && st_r.bit_cnt == `DPW_BIT_LAST
     && !line.start && !line.stop && !(st_r.command inside {`DPW_CMD_WIPER_A, `DPW_CMD_WIPER_B,
     `DPW_CMD_WIPER_BOTH})) |=> !load.load_a && !load.load_b)
    else $error("unknown command loaded a wiper");

  // the fall right after a start is not a data bit
  start_fall_a: assert property (@(posedge clk) disable iff (rst)
    (ce && st_r.state == dpw_pkg::DPW_ADDR && line.scl_fall && !st_r.bit_open && !line.start && !line.stop)
    |=> st_r.bit_cnt == $past(st_r.bit_cnt) && st_r.state == dpw_pkg::DPW_ADDR)
    else $error("start fall counted as a bit");

  // command byte is taken and acknowledged at its eighth fall
  cmd_ack_a: assert property (@(posedge clk) disable iff (rst)
    (ce && st_r.state == dpw_pkg::DPW_CMD && line.scl_fall && st_r.bit_open && st_r.bit_cnt == `DPW_BIT_LAST
     && !line.start && !line.stop) |=> !sda_oe_n && st_r.command == $past(st_r.shift))
    else $error("command byte not taken");

endmodule
`default_nettype wire

/* test/dpw_ctl_model.sv */
`timescale 1ns/1ps
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
// two-wire bus controller model, open-drain data line with pull-up
module dpw_ctl_model (
  // clock
  input  wire logic clk,
  // bus lines
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda_bus
);
  // idle bus: clock high and still, data released
  initial begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end

  // wait whole cycles, then move just after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // one bit: data changes while clock low, sampled mid high phase
  task automatic put_bit(input logic b, output logic seen);
    scl = 1'b0;
    tick(2);
    sda_drv = b;
    tick(2);
    scl = 1'b1;
    tick(2);
    seen = sda_bus;
    tick(2);
    scl = 1'b0;
  endtask

  // msb first, then a released ninth bit that reads the acknowledge
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(b[i], s);
    end
    put_bit(1'b1, s);
    ack = !s;
  endtask

  // start, address byte, command, data, stop
  task automatic frame(input logic [7:0] abyte, input logic [7:0] cmd, input logic [7:0] data,
                       output logic [2:0] acks);
    sda_drv = 1'b0;
    tick(4);
    put_byte(abyte, acks[2]);
    put_byte(cmd, acks[1]);
    put_byte(data, acks[0]);
    tick(2);
    sda_drv = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_drv = 1'b1;
    tick(4);
  endtask
endmodule

`default_nettype wire

/* test/dpw_slave_tb.sv */
`timescale 1ns/1ps
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
// bench for the wiper slave, driven by the controller model
module dpw_slave_tb;
  logic       clk;
  logic       rst;
  logic       ce;
  logic       scl;
  logic       sda_drv;
  logic       sda_bus;
  logic       sda_out;
  logic       sda_oe_n;
  logic [2:0] sel;
  logic [7:0] wa;
  logic [7:0] wb;
  logic [7:0] tap;
  logic [2:0] acks;
  int         n_mismatch;
  int         total_checks;

  // wired-and data line with pull-up
  assign sda_bus = sda_drv & (sda_oe_n | sda_out);

  dpw_slave dpw_slave_i (
    .clk              (clk),
    .rst              (rst),
    .ce               (ce),
    .scl_in           (scl),
    .sda_in           (sda_bus),
    .sda_out          (sda_out),
    .sda_oe_n         (sda_oe_n),
    .addr_select_msb  (sel[2]),
    .addr_select_mid  (sel[1]),
    .addr_select_lsb  (sel[0]),
    .wiper_out_first  (wa),
    .wiper_out_second (wb)
  );

  dpw_ctl_model dpw_ctl_model_i (
    .clk     (clk),
    .scl     (scl),
    .sda_drv (sda_drv),
    .sda_bus (sda_bus)
  );

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // compare one value, count and report
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one frame, then acknowledges and both taps
  task automatic wr(input logic [7:0] abyte, input logic [7:0] cmd, input logic [7:0] data,
                    input logic [2:0] ex_ack, input logic [7:0] ex_a, input logic [7:0] ex_b);
    dpw_ctl_model_i.frame(abyte, cmd, data, acks);
    check({5'h00, acks}, {5'h00, ex_ack});
    check(wa, ex_a);
    check(wb, ex_b);
  endtask

  // counts and verdict
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // watchdog well beyond the expected run length
  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    stop_test();
  end

  // test sequence
  initial begin
    rst          = 1'b1;
    sel          = 3'h0;
    ce           = 1'b1;
    n_mismatch   = 0;
    total_checks = 0;
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check(wa, 8'h80);
    check(wb, 8'h80);
    $display("test reset done");
    // each select setting: own address taken, neighbour refused
    for (int i = 0; i < 8; i++) begin
      sel = 3'(i);
      tap = (i == 7) ? 8'hFF : 8'(i * 37);
      wr(8'(8'h50 + 2 * i), 8'h11, tap, 3'b111, tap, 8'h80);
      wr(8'(8'h50 + 2 * (i ^ 1)), 8'h11, 8'h33, 3'b000, tap, 8'h80);
    end
    $display("test address select done");
    wr(8'h5E, 8'h12, 8'h3C, 3'b111, 8'hFF, 8'h3C);
    wr(8'h5E, 8'h13, 8'hA5, 3'b111, 8'hA5, 8'hA5);
    $display("test commands done");
    wr(8'h5E, 8'h14, 8'h01, 3'b111, 8'hA5, 8'hA5);
    wr(8'h5E, 8'h10, 8'h02, 3'b111, 8'hA5, 8'hA5);
    $display("test unknown command done");
    wr(8'h5F, 8'h11, 8'h00, 3'b000, 8'hA5, 8'hA5);
    $display("test read refused done");
    // frozen device ignores a whole frame
    ce = 1'b0;
    wr(8'h5E, 8'h11, 8'h00, 3'b000, 8'hA5, 8'hA5);
    ce = 1'b1;
    $display("test clock enable done");
    wr(8'h5E, 8'h13, 8'h80, 3'b111, 8'h80, 8'h80);
    $display("test midscale restore done");
    // reset in mid-run brings a moved wiper back to midscale
    wr(8'h5E, 8'h11, 8'h01, 3'b111, 8'h01, 8'h80);
    rst = 1'b1;
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check(wa, 8'h80);
    check(wb, 8'h80);
    $display("test mid-run reset done");
    stop_test();
  end
endmodule

`default_nettype wire
